// >>> bench/msi_and_subsystem_cap_regs_bench.sv
// Purpose: Self-checking bench for the interrupt and subsystem id registers
// Assumes: Inputs change on the falling edge, outputs are sampled there
// Notes:   Expected reads and messages queue up in order of issue
`timescale 1ns/1ps
module msi_and_subsystem_cap_regs_bench;
   logic                        core_clk_i, rst_i, lock_i, msg_req_i, rvalid, en;
   msi_subsystem_ident_pkg::cfg_req_type   req;
   msi_subsystem_ident_pkg::msg_write_type mw;
   logic [31:0]                 rdata, lo, hi, pay, v;
   logic [7:0]                  cnt;
   logic [31:0]                 rq[$];
   logic [96:0]                 mq[$];
   int                          miscompares, total_checks, cycles, nmsg;
   int                          seed = 32'h7ca82488;
   logic [11:0]                 offs[7] = '{msi_subsystem_ident_pkg::cap_control_off,
      msi_subsystem_ident_pkg::addr_low_off, msi_subsystem_ident_pkg::addr_high_off, msi_subsystem_ident_pkg::payload_off,
      msi_subsystem_ident_pkg::subsystem_ident_header_off, msi_subsystem_ident_pkg::subsystem_ident_values_off, 12'h0e0};
   logic [31:0]                 ev[3][7] = '{
      '{32'h0080_0005, 32'h0, 32'h0, 32'h0, 32'h0000_000d, 32'h0, 32'h0},
      '{32'h0081_ff05, 32'hffff_fffc, '1, 32'h0000_ffff, 32'h0000_ff0d, '1, 32'h0},
      '{32'h0080_ff05, 32'h0, 32'h0, 32'h0, 32'h0000_ff0d, '1, 32'h0}};

   msi_subsystem_ident_regs msi_subsystem_ident_regs_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .cfg_req_i(req),
      .lock_i(lock_i), .msg_req_i(msg_req_i), .cfg_rdata_o(rdata), .cfg_rvalid_o(rvalid),
      .msg_enable_o(en), .msg_write_o(mw));
   root_sink root_sink_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .msg_write_i(mw),
      .msg_count_o(cnt));

   initial
   begin
      core_clk_i = 1'h0;
      forever #2 core_clk_i = ~core_clk_i;
   end

   task automatic check(input logic [96:0] seen, input logic [96:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Holds the request to the next call, so back to back needs no gap
   task automatic bus(input logic rd, input logic wr, input logic [11:0] a,
                      input logic [3:0] be, input logic [31:0] d, input logic [31:0] exp);
      @(negedge core_clk_i);
      req = '{rd, wr, a, be, d};
      if (rd)
         rq.push_back(exp);
   endtask

   task automatic idle();
      @(negedge core_clk_i);
      req = '0;
      msg_req_i = 1'h0;
   endtask

   task automatic rdall(input int k);
      for (int i = 0; i < 7; i++)
         bus(1'h1, 1'h0, offs[i], 4'h0, 32'h0, ev[k][i]);
      idle();
   endtask

   task automatic wrall(input logic [31:0] d);
      for (int i = 0; i < 7; i++)
         bus(1'h0, 1'h1, offs[i], 4'hf, d, 32'h0);
      idle();
   endtask

   // Only an enabled block owes a message, so only then is one expected
   task automatic fire(input logic on);
      @(negedge core_clk_i);
      msg_req_i = 1'h1;
      if (on)
      begin
         mq.push_back({hi != 32'h0, hi, lo[31:2], 2'h0, 16'h0, pay[15:0]});
         nmsg++;
      end
   endtask

   always @(negedge core_clk_i)
   begin
      if (rvalid === 1'h1)
         check(rdata, rq.size() ? rq.pop_front() : 'x);
      if (mw.valid === 1'h1)
         check(mw[96:0], mq.size() ? mq.pop_front() : 'x);
   end

   always @(posedge core_clk_i)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         miscompares++;
         give_verdict();
      end
   end

   initial
   begin
      rst_i = 1'h1;
      lock_i = 1'h0;
      msg_req_i = 1'h0;
      req = '0;
      repeat (8) @(posedge core_clk_i);
      @(negedge core_clk_i);
      rst_i = 1'h0;
      rdall(0);
      $display("test 1 done");
      wrall('1);
      rdall(1);
      check(en, 1'h1);
      $display("test 2 done");
      lock_i = 1'h1;
      wrall('0);
      rdall(2);
      check(en, 1'h0);
      $display("test 3 done");
      lock_i = 1'h0;
      v = $random(seed);
      bus(1'h0, 1'h1, offs[5], 4'h5, v, 32'h0);
      bus(1'h1, 1'h0, offs[5], 4'h0, 32'h0, {8'hff, v[23:16], 8'hff, v[7:0]});
      idle();
      fire(1'h0);
      idle();
      lo = $random(seed);
      hi = 32'h0;
      pay = $random(seed);
      // Software stands in for the root side: address assumed root-bound
      bus(1'h0, 1'h1, offs[1], 4'hf, lo, 32'h0);
      bus(1'h0, 1'h1, offs[3], 4'hf, pay, 32'h0);
      bus(1'h0, 1'h1, offs[0], 4'h4, 32'h0001_0000, 32'h0);
      idle();
      fire(1'h1);
      fire(1'h1);
      idle();
      hi = $random(seed) | 32'h1;
      bus(1'h0, 1'h1, offs[2], 4'hf, hi, 32'h0);
      idle();
      fire(1'h1);
      idle();
      repeat (4) idle();
      check(cnt, nmsg[7:0]);
      check(rq.size() + mq.size(), 97'h0);
      $display("test 4 done");
      give_verdict();
   end
endmodule // msi_and_subsystem_cap_regs_bench

// >>> bench/root_sink.sv
// Purpose: Root port sink that counts interrupt writes
// Assumes: Writes arrive as one-cycle valid pulses
// Notes:   Always ready, a root port never stalls posted writes
`timescale 1ns/1ps
module root_sink
(
   input  wire logic                        core_clk_i,
   input  wire logic                        rst_i,
   input  wire msi_subsystem_ident_pkg::msg_write_type msg_write_i,
   output logic [7:0]                       msg_count_o
);
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
         msg_count_o <= 8'h00;
      else if (msg_write_i.valid)
         msg_count_o <= msg_count_o + 8'h01;
   end
endmodule // root_sink

// >>> design/msi_subsystem_ident_pkg.sv
// Purpose: Constants and carrier types for the interrupt message and subsystem id registers
// Assumes: 32-bit configuration accesses with byte enables, dword addressed by byte offset
// Notes:   Offsets are configuration space byte addresses
package msi_subsystem_ident_pkg;
   localparam logic [11:0] cap_control_off   = 12'h0d0;
   localparam logic [11:0] addr_low_off      = 12'h0d4;
   localparam logic [11:0] addr_high_off     = 12'h0d8;
   localparam logic [11:0] payload_off       = 12'h0dc;
   localparam logic [11:0] subsystem_ident_header_off   = 12'h0f0;
   localparam logic [11:0] subsystem_ident_values_off   = 12'h0f4;

   localparam logic [7:0]  msi_cap_ident     = 8'h05;
   localparam logic [7:0]  subsystem_ident_cap_ident    = 8'h0d;
   localparam logic [7:0]  next_ptr_reset    = 8'h00;
   localparam logic [2:0]  req_count_value   = 3'h0;
   localparam logic [2:0]  granted_value     = 3'h0;
   localparam logic        wide_capable_bit  = 1'h1;
   localparam logic [31:0] zero_word         = 32'h0000_0000;
   localparam logic [15:0] zero_half         = 16'h0000;

   // Configuration access request from the port's config logic
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [11:0] addr;
      logic [3:0]  be;
      logic [31:0] wdata;
   } cfg_req_type;

   // Interrupt memory write handed to the transmit side
   typedef struct packed {
      logic        valid;
      logic        wide;
      logic [63:0] addr;
      logic [31:0] data;
   } msg_write_type;
endpackage

// >>> design/msi_subsystem_ident_regs.sv
// Purpose: Interrupt message and subsystem identification capability register bank
// Assumes: Single core clock, synchronous active high reset, lock input from the port
// Notes:   Read data is registered and valid one cycle after the read strobe
//
// How it works
// - Interrupt capability id reads fixed 0x5
// - Interrupt next pointer lockable-writable, resets 0x0
// - Enable bit 16 read-write, resets zero
// - Requested message count reads zero
// - Granted message count fixed single message
// - Bit 23 reads one, wide address
// - Lower address bits 31:2 stored, 1:0 zero
// - Nonzero upper address selects wide write
// - Payload low 16 bits, upper bits zero
// - Subsystem capability id reads fixed 0xD
// - Subsystem next pointer lockable, upper reserved zero
// - Vendor ident lockable-writable, resets zero
// - Subsystem ident lockable-writable, resets zero
`timescale 1ns/1ps
module msi_subsystem_ident_regs
(
   input  wire logic                         core_clk_i,
   input  wire logic                         rst_i,
   input  wire msi_subsystem_ident_pkg::cfg_req_type    cfg_req_i,
   input  wire logic                         lock_i,
   input  wire logic                         msg_req_i,
   output logic [31:0]                       cfg_rdata_o,
   output logic                              cfg_rvalid_o,
   output logic                              msg_enable_o,
   output msi_subsystem_ident_pkg::msg_write_type       msg_write_o
);

   logic [7:0]  msi_next_r;
   logic        enable_r;
   logic [29:0] addr_low_r;
   logic [31:0] addr_high_r;
   logic [15:0] payload_r;
   logic [7:0]  subsystem_ident_next_r;
   logic [15:0] vendor_ident_r;
   logic [15:0] sub_ident_r;
   logic [31:0] rdata_nxt;

   // Byte-enable merge used by every writable field
   function automatic logic [31:0] merge
   (
      input logic [31:0] old_v,
      input logic [31:0] new_v,
      input logic [3:0]  be
   );
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++)
      begin
         if (be[i])
         begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction

   function automatic logic hit(input logic [11:0] off);
      return cfg_req_i.wr && (cfg_req_i.addr == off);
   endfunction

   logic [31:0] cap_word;
   logic [31:0] low_word;
   logic [31:0] subsystem_ident_hdr_word;
   logic [31:0] subsystem_ident_val_word;
   logic [31:0] cap_m;
   logic [31:0] low_m;
   logic [31:0] high_m;
   logic [31:0] pay_m;
   logic [31:0] hdr_m;
   logic [31:0] val_m;

   always_comb
   begin
      cap_word = {8'h00, msi_subsystem_ident_pkg::wide_capable_bit,
                  msi_subsystem_ident_pkg::granted_value,
                  msi_subsystem_ident_pkg::req_count_value,
                  enable_r, msi_next_r,
                  msi_subsystem_ident_pkg::msi_cap_ident};
      low_word = {addr_low_r, 2'b00};
      subsystem_ident_hdr_word = {msi_subsystem_ident_pkg::zero_half, subsystem_ident_next_r,
                       msi_subsystem_ident_pkg::subsystem_ident_cap_ident};
      subsystem_ident_val_word = {sub_ident_r, vendor_ident_r};
      cap_m  = merge(cap_word, cfg_req_i.wdata, cfg_req_i.be);
      low_m  = merge(low_word, cfg_req_i.wdata, cfg_req_i.be);
      high_m = merge(addr_high_r, cfg_req_i.wdata, cfg_req_i.be);
      pay_m  = merge({msi_subsystem_ident_pkg::zero_half, payload_r}, cfg_req_i.wdata, cfg_req_i.be);
      hdr_m  = merge(subsystem_ident_hdr_word, cfg_req_i.wdata, cfg_req_i.be);
      val_m  = merge(subsystem_ident_val_word, cfg_req_i.wdata, cfg_req_i.be);
   end

   // Interrupt capability control; granted count ignores writes
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         msi_next_r <= msi_subsystem_ident_pkg::next_ptr_reset;
         enable_r   <= 1'b0;
      end
      else if (hit(msi_subsystem_ident_pkg::cap_control_off))
      begin
         if (!lock_i)
         begin
            msi_next_r <= cap_m[15:8];
         end
         enable_r <= cap_m[16];
      end
   end

   // Message address and payload
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         addr_low_r  <= '0;
         addr_high_r <= msi_subsystem_ident_pkg::zero_word;
         payload_r   <= msi_subsystem_ident_pkg::zero_half;
      end
      else
      begin
         if (hit(msi_subsystem_ident_pkg::addr_low_off))
         begin
            addr_low_r <= low_m[31:2];
         end
         if (hit(msi_subsystem_ident_pkg::addr_high_off))
         begin
            addr_high_r <= high_m;
         end
         if (hit(msi_subsystem_ident_pkg::payload_off))
         begin
            payload_r <= pay_m[15:0];
         end
      end
   end

   // Subsystem identification; frozen while locked
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         subsystem_ident_next_r    <= msi_subsystem_ident_pkg::next_ptr_reset;
         vendor_ident_r <= msi_subsystem_ident_pkg::zero_half;
         sub_ident_r    <= msi_subsystem_ident_pkg::zero_half;
      end
      else if (!lock_i)
      begin
         if (hit(msi_subsystem_ident_pkg::subsystem_ident_header_off))
         begin
            subsystem_ident_next_r <= hdr_m[15:8];
         end
         if (hit(msi_subsystem_ident_pkg::subsystem_ident_values_off))
         begin
            vendor_ident_r <= val_m[15:0];
            sub_ident_r    <= val_m[31:16];
         end
      end
   end

   // Read mux; unmapped offsets read zero
   always_comb
   begin
      case (cfg_req_i.addr)
         msi_subsystem_ident_pkg::cap_control_off: rdata_nxt = cap_word;
         msi_subsystem_ident_pkg::addr_low_off:    rdata_nxt = low_word;
         msi_subsystem_ident_pkg::addr_high_off:   rdata_nxt = addr_high_r;
         msi_subsystem_ident_pkg::payload_off:     rdata_nxt = {msi_subsystem_ident_pkg::zero_half, payload_r};
         msi_subsystem_ident_pkg::subsystem_ident_header_off: rdata_nxt = subsystem_ident_hdr_word;
         msi_subsystem_ident_pkg::subsystem_ident_values_off: rdata_nxt = subsystem_ident_val_word;
         default:                       rdata_nxt = msi_subsystem_ident_pkg::zero_word;
      endcase
   end

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         cfg_rdata_o  <= msi_subsystem_ident_pkg::zero_word;
         cfg_rvalid_o <= 1'b0;
      end
      else
      begin
         cfg_rdata_o  <= cfg_req_i.rd ? rdata_nxt : msi_subsystem_ident_pkg::zero_word;
         cfg_rvalid_o <= cfg_req_i.rd;
      end
   end

   // Message write; address routing to the root is software's job
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         msg_write_o  <= '0;
         msg_enable_o <= 1'b0;
      end
      else
      begin
         msg_enable_o      <= enable_r;
         msg_write_o.valid <= msg_req_i && enable_r;
         msg_write_o.wide  <= (addr_high_r != msi_subsystem_ident_pkg::zero_word);
         msg_write_o.addr  <= (addr_high_r != msi_subsystem_ident_pkg::zero_word)
                              ? {addr_high_r, addr_low_r, 2'b00}
                              : {msi_subsystem_ident_pkg::zero_word, addr_low_r, 2'b00};
         msg_write_o.data  <= {msi_subsystem_ident_pkg::zero_half, payload_r};
      end
   end

   // Checks
   property p_msg_gated;
      @(posedge core_clk_i) disable iff (rst_i)
      msg_write_o.valid |-> $past(msg_req_i) && $past(enable_r);
   endproperty
   a_msg_gated: assert property (p_msg_gated) else $error("message without enable");

   property p_msg_sent;
      @(posedge core_clk_i) disable iff (rst_i)
      msg_req_i && enable_r |=> msg_write_o.valid;
   endproperty
   a_msg_sent: assert property (p_msg_sent) else $error("enabled message lost");

   property p_wide;
      @(posedge core_clk_i) disable iff (rst_i)
      msg_write_o.valid |-> msg_write_o.wide == (msg_write_o.addr[63:32] != 32'h0000_0000);
   endproperty
   a_wide: assert property (p_wide) else $error("wide flag mismatch");

   property p_addr_align;
      @(posedge core_clk_i) disable iff (rst_i)
      msg_write_o.valid |-> msg_write_o.addr[1:0] == 2'h0;
   endproperty
   a_addr_align: assert property (p_addr_align) else $error("address not aligned");

   property p_data_high;
      @(posedge core_clk_i) disable iff (rst_i)
      msg_write_o.valid |-> msg_write_o.data[31:16] == 16'h0000;
   endproperty
   a_data_high: assert property (p_data_high) else $error("payload upper bits set");

   property p_cap_read;
      @(posedge core_clk_i) disable iff (rst_i)
      cfg_req_i.rd && cfg_req_i.addr == msi_subsystem_ident_pkg::cap_control_off
      |=> cfg_rdata_o[7:0] == 8'h05 && cfg_rdata_o[23:17] == 7'h40
          && cfg_rdata_o[31:24] == 8'h00;
   endproperty
   a_cap_read: assert property (p_cap_read) else $error("capability header wrong");

   property p_subsystem_ident_read;
      @(posedge core_clk_i) disable iff (rst_i)
      cfg_req_i.rd && cfg_req_i.addr == msi_subsystem_ident_pkg::subsystem_ident_header_off
      |=> cfg_rdata_o[7:0] == 8'h0d && cfg_rdata_o[31:16] == 16'h0000;
   endproperty
   a_subsystem_ident_read: assert property (p_subsystem_ident_read) else $error("subsystem header wrong");

   property p_lock_hold;
      @(posedge core_clk_i) disable iff (rst_i)
      lock_i |=> $stable(vendor_ident_r) && $stable(sub_ident_r) && $stable(subsystem_ident_next_r)
                 && $stable(msi_next_r);
   endproperty
   a_lock_hold: assert property (p_lock_hold) else $error("locked field changed");

   property p_enable_wr;
      @(posedge core_clk_i) disable iff (rst_i)
      hit(msi_subsystem_ident_pkg::cap_control_off) && cfg_req_i.be[2]
      |=> enable_r == $past(cfg_req_i.wdata[16]);
   endproperty
   a_enable_wr: assert property (p_enable_wr) else $error("enable not written");

   c_msg_narrow: cover property (@(posedge core_clk_i) msg_write_o.valid && !msg_write_o.wide);
   c_msg_wide:   cover property (@(posedge core_clk_i) msg_write_o.valid && msg_write_o.wide);
   c_lock_write: cover property (@(posedge core_clk_i) lock_i && cfg_req_i.wr);
   c_blocked:    cover property (@(posedge core_clk_i) msg_req_i && !enable_r);

endmodule // msi_subsystem_ident_regs
